// *** common/uoec_pkg.sv ***
package uoec_pkg;

    localparam int EP_NUM = 3;
    localparam int REG_W = 8;
    localparam int BUF_ADDR_W = 11;
    localparam int ADDR_PAD_W = 3;

    // endpoint descriptor bases in the controller's external data space
    localparam logic [15:0] EP1_BASE = 16'hff08;
    localparam logic [15:0] EP2_BASE = 16'hff10;
    localparam logic [15:0] EP3_BASE = 16'hff18;

    // entry offsets inside one descriptor block
    localparam logic [2:0] OFS_CONFIG = 3'h0;
    localparam logic [2:0] OFS_XBASE = 3'h1;

    // configuration field positions
    localparam int CFG_ENABLE_BIT = 7;
    localparam int CFG_ISO_BIT = 6;
    localparam int CFG_TOGGLE_BIT = 5;
    localparam int CFG_DUAL_BIT = 4;
    localparam int CFG_STALL_BIT = 3;
    localparam int CFG_IE_BIT = 2;

    // writable bits; the two low bits are reserved and read as zero
    localparam logic [7:0] CFG_WMASK = 8'hfc;

    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] XBASE_RESET = 8'h00;

    typedef enum logic [0:0] {
        UOEC_IDLE,
        UOEC_BUSY
    } uoec_state_t;

endpackage

// *** verilog/uoec_ep_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module uoec_ep_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_cfg,
    input wire logic wr_xbase,
    input wire logic [7:0] wdata,
    input wire logic flip_toggle,
    output logic [7:0] cfg_r,
    output logic [7:0] xbase_r
);

    logic [7:0] cfg_nxt;
    logic [7:0] xbase_nxt;

    always_comb
    begin
        cfg_nxt = cfg_r;
        xbase_nxt = xbase_r;
        if (wr_cfg)
        begin
            cfg_nxt = wdata & uoec_pkg::CFG_WMASK;
        end
        // hardware toggle update wins over a same-cycle write
        if (flip_toggle)
        begin
            cfg_nxt[uoec_pkg::CFG_TOGGLE_BIT] =
                ~cfg_r[uoec_pkg::CFG_TOGGLE_BIT];
        end
        // only the controller writes the base; no completion path here
        if (wr_xbase)
        begin
            xbase_nxt = wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cfg_r <= uoec_pkg::CFG_RESET;
            xbase_r <= uoec_pkg::XBASE_RESET;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            xbase_r <= xbase_nxt;
        end
    end

endmodule // uoec_ep_regs

`default_nettype wire

// *** verilog/uoec_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module uoec_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] mcu_addr,
    input wire logic mcu_wr,
    input wire logic mcu_rd,
    input wire logic [7:0] mcu_wdata,
    output logic [7:0] mcu_rdata,
    output logic mcu_hit,
    input wire logic txn_start,
    input wire logic [1:0] txn_ep,
    input wire logic txn_done,
    input wire logic txn_ok,
    output logic txn_ack,
    output logic txn_grant,
    output logic txn_stall,
    output logic [10:0] txn_addr,
    output logic txn_use_y,
    output logic txn_toggle,
    output logic irq_done,
    output logic [1:0] irq_ep
);

    localparam logic [15:0] EP_BASE [uoec_pkg::EP_NUM] = '{
        uoec_pkg::EP1_BASE, uoec_pkg::EP2_BASE, uoec_pkg::EP3_BASE};

    // endpoint index 1..3 for a descriptor address, 0 when unmapped
    function automatic logic [1:0] ep_of(input logic [15:0] a);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < uoec_pkg::EP_NUM; i++)
        begin
            if (a[15:3] == EP_BASE[i][15:3])
            begin
                r = 2'(i + 1);
            end
        end
        return r;
    endfunction

    logic [7:0] cfg [uoec_pkg::EP_NUM];
    logic [7:0] xbase [uoec_pkg::EP_NUM];
    logic [uoec_pkg::EP_NUM-1:0] wr_cfg;
    logic [uoec_pkg::EP_NUM-1:0] wr_xbase;
    logic [uoec_pkg::EP_NUM-1:0] flip;
    logic [1:0] bus_ep;
    logic bus_cfg;
    logic bus_xb;

    assign bus_ep = ep_of(mcu_addr);
    assign bus_cfg = (mcu_addr[2:0] == uoec_pkg::OFS_CONFIG);
    assign bus_xb = (mcu_addr[2:0] == uoec_pkg::OFS_XBASE);

    genvar g;
    generate
        for (g = 0; g < uoec_pkg::EP_NUM; g++)
        begin : g_ep
            assign wr_cfg[g] = mcu_wr && bus_ep == 2'(g + 1) && bus_cfg;
            assign wr_xbase[g] = mcu_wr && bus_ep == 2'(g + 1) && bus_xb;
            uoec_ep_regs u_regs (
                .clk(clk),
                .rstn(rstn),
                .wr_cfg(wr_cfg[g]),
                .wr_xbase(wr_xbase[g]),
                .wdata(mcu_wdata),
                .flip_toggle(flip[g]),
                .cfg_r(cfg[g]),
                .xbase_r(xbase[g])
            );
        end
    endgenerate

    // register read port: data one cycle after the read strobe
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic hit_r;
    logic hit_nxt;

    always_comb
    begin
        rdata_nxt = rdata_r;
        hit_nxt = 1'b0;
        if (mcu_rd)
        begin
            rdata_nxt = 8'h00;
            if (bus_ep != 2'h0 && bus_cfg)
            begin
                rdata_nxt = cfg[bus_ep - 2'h1];
                hit_nxt = 1'b1;
            end
            else if (bus_ep != 2'h0 && bus_xb)
            begin
                rdata_nxt = xbase[bus_ep - 2'h1];
                hit_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rdata_r <= 8'h00;
            hit_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign mcu_rdata = rdata_r;
    assign mcu_hit = hit_r;

    // transaction service for the buffer manager
    uoec_pkg::uoec_state_t state_r;
    uoec_pkg::uoec_state_t state_nxt;
    logic [1:0] ep_r;
    logic [1:0] ep_nxt;
    logic ack_r, ack_nxt, grant_r, grant_nxt, stall_r, stall_nxt;
    logic [10:0] addr_r, addr_nxt;
    logic use_y_r, use_y_nxt, tog_r, tog_nxt;
    logic irq_r, irq_nxt;
    logic [1:0] irq_ep_r, irq_ep_nxt;
    logic start_ok;
    logic [7:0] start_cfg;
    logic [7:0] start_xbase;
    logic [7:0] cur_cfg;

    assign start_ok = txn_start && state_r == uoec_pkg::UOEC_IDLE
        && txn_ep != 2'h0;
    assign start_cfg = (txn_ep != 2'h0) ? cfg[txn_ep - 2'h1] : 8'h00;
    assign start_xbase = (txn_ep != 2'h0) ? xbase[txn_ep - 2'h1] : 8'h00;
    assign cur_cfg = (ep_r != 2'h0) ? cfg[ep_r - 2'h1] : 8'h00;

    always_comb
    begin
        state_nxt = state_r;
        ep_nxt = ep_r;
        ack_nxt = 1'b0;
        grant_nxt = 1'b0;
        stall_nxt = stall_r;
        addr_nxt = addr_r;
        use_y_nxt = use_y_r;
        tog_nxt = tog_r;
        irq_nxt = 1'b0;
        irq_ep_nxt = irq_ep_r;
        flip = '0;
        unique case (state_r)
            uoec_pkg::UOEC_IDLE:
            begin
                if (start_ok)
                begin
                    ack_nxt = 1'b1;
                    ep_nxt = txn_ep;
                    stall_nxt = start_cfg[uoec_pkg::CFG_STALL_BIT];
                    grant_nxt = start_cfg[uoec_pkg::CFG_ENABLE_BIT]
                        && !start_cfg[uoec_pkg::CFG_STALL_BIT];
                    addr_nxt = {start_xbase,
                        {uoec_pkg::ADDR_PAD_W{1'b0}}};
                    tog_nxt = start_cfg[uoec_pkg::CFG_TOGGLE_BIT];
                    use_y_nxt = start_cfg[uoec_pkg::CFG_DUAL_BIT]
                        && start_cfg[uoec_pkg::CFG_TOGGLE_BIT];
                    if (grant_nxt)
                    begin
                        state_nxt = uoec_pkg::UOEC_BUSY;
                    end
                end
            end
            uoec_pkg::UOEC_BUSY:
            begin
                if (txn_done)
                begin
                    state_nxt = uoec_pkg::UOEC_IDLE;
                    if (txn_ok)
                    begin
                        flip[ep_r - 2'h1] = 1'b1;
                        irq_nxt = cur_cfg[uoec_pkg::CFG_IE_BIT];
                        irq_ep_nxt = ep_r;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= uoec_pkg::UOEC_IDLE;
            ep_r <= 2'h0;
            ack_r <= 1'b0;
            grant_r <= 1'b0;
            stall_r <= 1'b0;
            addr_r <= 11'h000;
            use_y_r <= 1'b0;
            tog_r <= 1'b0;
            irq_r <= 1'b0;
            irq_ep_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            ep_r <= ep_nxt;
            ack_r <= ack_nxt;
            grant_r <= grant_nxt;
            stall_r <= stall_nxt;
            addr_r <= addr_nxt;
            use_y_r <= use_y_nxt;
            tog_r <= tog_nxt;
            irq_r <= irq_nxt;
            irq_ep_r <= irq_ep_nxt;
        end
    end

    assign txn_ack = ack_r;
    assign txn_grant = grant_r;
    assign txn_stall = stall_r;
    assign txn_addr = addr_r;
    assign txn_use_y = use_y_r;
    assign txn_toggle = tog_r;
    assign irq_done = irq_r;
    assign irq_ep = irq_ep_r;

    logic [23:0] xbase_all;
    assign xbase_all = {xbase[2], xbase[1], xbase[0]};

    a_disabled_refused: assert property (@(posedge clk) disable iff (!rstn)
        start_ok && !start_cfg[uoec_pkg::CFG_ENABLE_BIT]
        |=> txn_ack && !txn_grant && state_r == uoec_pkg::UOEC_IDLE)
        else $error("disabled endpoint was granted");
    a_irq_enable_gate: assert property (@(posedge clk) disable iff (!rstn)
        state_r == uoec_pkg::UOEC_BUSY && txn_done && txn_ok
        |=> irq_done == $past(cur_cfg[uoec_pkg::CFG_IE_BIT])
            && (!irq_done || irq_ep == $past(ep_r)))
        else $error("completion interrupt wrong");
    a_no_stray_irq: assert property (@(posedge clk) disable iff (!rstn)
        irq_done |-> $past(state_r == uoec_pkg::UOEC_BUSY && txn_done))
        else $error("interrupt without completion");
    a_stall_answer: assert property (@(posedge clk) disable iff (!rstn)
        start_ok && start_cfg[uoec_pkg::CFG_STALL_BIT]
        |=> txn_ack && txn_stall && !txn_grant)
        else $error("stall not signalled");
    a_start_address: assert property (@(posedge clk) disable iff (!rstn)
        start_ok |=> txn_addr == {$past(start_xbase), 3'b000})
        else $error("start address mismatch");
    a_addr_held: assert property (@(posedge clk) disable iff (!rstn)
        state_r == uoec_pkg::UOEC_BUSY |=> $stable(txn_addr))
        else $error("address moved during transaction");
    a_base_kept: assert property (@(posedge clk) disable iff (!rstn)
        !mcu_wr |=> $stable(xbase_all))
        else $error("base changed without a write");
    a_toggle_flips: assert property (@(posedge clk) disable iff (!rstn)
        state_r == uoec_pkg::UOEC_BUSY && txn_done && txn_ok
        |=> cur_cfg[uoec_pkg::CFG_TOGGLE_BIT]
            != $past(cur_cfg[uoec_pkg::CFG_TOGGLE_BIT]))
        else $error("toggle did not flip");
    a_buffer_select: assert property (@(posedge clk) disable iff (!rstn)
        start_ok |=> txn_use_y == ($past(start_cfg[uoec_pkg::CFG_DUAL_BIT])
            && $past(start_cfg[uoec_pkg::CFG_TOGGLE_BIT])))
        else $error("wrong buffer selected");

endmodule // uoec_top

`default_nettype wire

// *** verif/uoec_bm_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module uoec_bm_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic go,
    input wire logic [1:0] ep,
    input wire logic ok,
    input wire logic [3:0] dly,
    input wire logic txn_ack,
    input wire logic txn_grant,
    output logic txn_start,
    output logic [1:0] txn_ep,
    output logic txn_done,
    output logic txn_ok,
    output logic busy
);
    int n;

    initial
    begin
        txn_start = 1'b0;
        txn_ep = 2'h0;
        txn_done = 1'b0;
        txn_ok = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go && rstn)
            begin
                busy <= 1'b1;
                txn_start <= 1'b1;
                txn_ep <= ep;
                @(posedge clk);
                txn_start <= 1'b0;
                txn_ep <= ~ep;
                n = 0;
                while (txn_ack !== 1'b1 && n < 8)
                begin
                    @(posedge clk);
                    n++;
                end
                // only a granted endpoint is serviced
                if (txn_grant === 1'b1)
                begin
                    repeat (dly) @(posedge clk);
                    txn_done <= 1'b1;
                    txn_ok <= ok;
                    @(posedge clk);
                    txn_done <= 1'b0;
                    txn_ok <= ~ok;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule // uoec_bm_model

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct packed {
        logic [1:0] ep;
        logic [7:0] cfg;
        logic [7:0] base;
        logic ok;
        logic [3:0] dly;
        logic [4:0] exp;
        logic [7:0] cfg_after;
    } uoec_row_t;

    logic clk, rstn, mcu_wr, mcu_rd, mcu_hit, go, go_ok, busy;
    logic [15:0] mcu_addr, a;
    logic [7:0] mcu_wdata, mcu_rdata;
    logic txn_start, txn_done, txn_ok, txn_ack, txn_grant, txn_stall;
    logic txn_use_y, txn_toggle, irq_done;
    logic [1:0] txn_ep, irq_ep, go_ep, irq_ep_seen;
    logic [10:0] txn_addr, got_addr;
    logic [3:0] go_dly, got;
    int n_errors = 0, checks = 0, acks = 0, irqs = 0, cyc = 0, i0, a0;
    // ep, cfg, base, ok, dly, {grant,stall,use_y,toggle,irq}, cfg after
    uoec_row_t rows [0:6] = '{
        '{2'h1, 8'h87, 8'h12, 1'b1, 4'h0, 5'h11, 8'ha4},
        '{2'h2, 8'hb4, 8'hff, 1'b1, 4'h3, 5'h17, 8'h94},
        '{2'h3, 8'h80, 8'h00, 1'b1, 4'h0, 5'h10, 8'ha0},
        '{2'h1, 8'h00, 8'h01, 1'b1, 4'h0, 5'h00, 8'h00},
        '{2'h2, 8'h8c, 8'h20, 1'b1, 4'h0, 5'h08, 8'h8c},
        '{2'h3, 8'h90, 8'h7e, 1'b0, 4'h1, 5'h10, 8'h90},
        '{2'h2, 8'h84, 8'h40, 1'b1, 4'h2, 5'h11, 8'ha4}};

    uoec_top dut (.clk(clk), .rstn(rstn), .mcu_addr(mcu_addr),
        .mcu_wr(mcu_wr), .mcu_rd(mcu_rd), .mcu_wdata(mcu_wdata),
        .mcu_rdata(mcu_rdata), .mcu_hit(mcu_hit), .txn_start(txn_start),
        .txn_ep(txn_ep), .txn_done(txn_done), .txn_ok(txn_ok),
        .txn_ack(txn_ack), .txn_grant(txn_grant), .txn_stall(txn_stall),
        .txn_addr(txn_addr), .txn_use_y(txn_use_y),
        .txn_toggle(txn_toggle), .irq_done(irq_done), .irq_ep(irq_ep));

    uoec_bm_model bm (.clk(clk), .rstn(rstn), .go(go), .ep(go_ep),
        .ok(go_ok), .dly(go_dly), .txn_ack(txn_ack),
        .txn_grant(txn_grant), .txn_start(txn_start), .txn_ep(txn_ep),
        .txn_done(txn_done), .txn_ok(txn_ok), .busy(busy));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge clk);
        mcu_addr <= ad;
        mcu_wdata <= d;
        mcu_wr <= 1'b1;
        @(posedge clk);
        mcu_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] ad, input logic [7:0] ed,
        input logic eh, input string nm);
        @(posedge clk);
        mcu_addr <= ad;
        mcu_rd <= 1'b1;
        @(posedge clk);
        mcu_rd <= 1'b0;
        @(posedge clk);
        chk(nm, mcu_rdata, ed);
        chk({nm, " hit"}, mcu_hit, eh);
    endtask

    task automatic run_txn(input logic [1:0] e, input logic k,
        input logic [3:0] d);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        go_ep <= e;
        go_ok <= k;
        go_dly <= d;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy !== 1'b0 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (txn_ack === 1'b1)
        begin
            got = {txn_grant, txn_stall, txn_use_y, txn_toggle};
            got_addr = txn_addr;
            acks++;
        end
        if (irq_done === 1'b1)
        begin
            irqs++;
            irq_ep_seen = irq_ep;
        end
        if (cyc == 5000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    initial
    begin
        {rstn, mcu_wr, mcu_rd, go, go_ok} = 5'h00;
        {mcu_addr, mcu_wdata, go_ep, go_dly} = 30'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int e = 1; e < 4; e++)
        begin
            rd(16'hff00 | (e << 3), 8'h00, 1'b1, "cfg reset");
            rd(16'hff01 | (e << 3), 8'h00, 1'b1, "xbase reset");
        end
        $display("reset values done");
        for (int i = 0; i < 7; i++)
        begin
            a = 16'hff00 | {11'h0, rows[i].ep, 3'h0};
            wr(a | 16'h1, rows[i].base);
            wr(a, rows[i].cfg);
            i0 = irqs;
            a0 = acks;
            run_txn(rows[i].ep, rows[i].ok, rows[i].dly);
            chk("acks", acks - a0, 16'h1);
            chk("ack flags", got, rows[i].exp[4:1]);
            chk("start addr", got_addr, {rows[i].base, 3'h0});
            chk("irq count", irqs - i0, rows[i].exp[0]);
            if (rows[i].exp[0])
                chk("irq ep", irq_ep_seen, rows[i].ep);
            rd(a, rows[i].cfg_after, 1'b1, "cfg after");
            rd(a | 16'h1, rows[i].base, 1'b1, "xbase after");
            $display("row %0d done", i);
        end
        wr(16'hff0b, 8'h5a);
        rd(16'hff0b, 8'h00, 1'b0, "unmapped");
        a0 = acks;
        run_txn(2'h0, 1'b1, 4'h0);
        chk("ep0 ignored", acks - a0, 16'h0);
        $display("refusals done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(16'hff10, 8'h00, 1'b1, "cfg rereset");
        rd(16'hff11, 8'h00, 1'b1, "xbase rereset");
        $display("second reset done");
        end_of_test();
    end
endmodule // tb

`default_nettype wire
